/* design/dso_map.svh */
/*
  Register offsets, field positions, reset values and hysteresis divisors
  of the drive status output block.
  Assumes byte addresses on a 32-bit classic Wishbone bus, one word each.
*/
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH

// register byte offsets
`define DSO_SEL0_OFS    8'h00
`define DSO_SEL1_OFS    8'h04
`define DSO_SEL2_OFS    8'h08
`define DSO_SETF_OFS    8'h0c
`define DSO_ACCTH_OFS   8'h10
`define DSO_DECTH_OFS   8'h14
`define DSO_STARTF_OFS  8'h18
`define DSO_MAXF_OFS    8'h1c
`define DSO_STAT_OFS    8'h20
`define DSO_ISTAT_OFS   8'h24
`define DSO_IMASK_OFS   8'h28

// live status register fields
`define DSO_ST_RUN_BIT  0
`define DSO_ST_FA1_BIT  1
`define DSO_ST_FA2_BIT  2
`define DSO_ST_RLY_LSB  3

// reset values, frequencies in 0.01 Hz
`define DSO_FREQ_RST    16'h0000
`define DSO_STARTF_RST  16'h0032
`define DSO_MAXF_RST    16'h1770

// hysteresis: on early by max/100, off late by max/50
`define DSO_HYST_ON_DIV  16'h0064
`define DSO_HYST_OFF_DIV 16'h0032

`endif

/* design/dso_pkg.sv */
/*
  Types of the drive status output block: status function codes and
  the frequency word.
  Assumes dso_map.svh carries all offsets and the frequency reset values.
*/
package dso_pkg;

  // status function codes a relay can be assigned
  typedef enum logic [7:0] {
    DSO_FN_RUN   = 8'h00,
    DSO_FN_FA1   = 8'h01,
    DSO_FN_FA2   = 8'h02,
    DSO_FN_ALARM = 8'h05
  } dso_fn_e;

  typedef logic [15:0] dso_freq_t;

endpackage

/* design/dso_status_out.sv */
/*
  Drive status output logic: run and frequency-arrival indicators mapped
  onto two normally open relays and one changeover alarm relay, with a
  classic Wishbone register slave and a level interrupt.
  Assumes drive state inputs (run, fault, accel, decel, frequency) come
  from logic on clk_i, so they are used without synchronisers.
*/
// Decided for this implementation: the Wishbone register port and the register offsets.
// Behaviour
// - two NO relays, each independently assigned any status function
// - alarm relay defaults to fault alarm, accepts any relay function
// - code 00 output active while running, inactive while stopped
// - active output closes contacts; open contacts mean inactive
// - run indicator asserted when output frequency exceeds start frequency
// - code 01 active when output frequency equals set frequency
// - code 02 turns on during accel at or above accel threshold
// - threshold arrival turns on in accel, off at another decel frequency
// - every arrival transition has hysteresis against chatter
// - hysteresis: on early by 1% max, off late by 2% max
// - over-threshold output turns off in decel below decel threshold
`timescale 1ns/1ps
`include "dso_map.svh"

module dso_status_out
  import dso_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        run_i,
  input  wire logic        fault_i,
  input  wire logic        accel_i,
  input  wire logic        decel_i,
  input  wire dso_freq_t   out_freq_i,
  output logic             relay1_o,
  output logic             relay2_o,
  output logic             alarm_no_o,
  output logic             alarm_nc_o,
  output logic             irq_o
);

  // three selection codes: relay 1, relay 2 and the alarm relay
  logic [7:0]  sel_q [3];
  logic [7:0]  sel_d [3];
  dso_freq_t   setf_q, accth_q, decth_q, startf_q, maxf_q;
  dso_freq_t   setf_d, accth_d, decth_d, startf_d, maxf_d;
  logic [2:0]  istat_q, istat_d, imask_q, imask_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        irq_q, irq_d;
  logic        fa1_q, fa1_d, fa2_q, fa2_d;
  logic [2:0]  relay_q, relay_d;
  logic        nc_q, nc_d;
  logic        req, wr;
  logic [7:0]  adr;
  dso_freq_t   hon, hoff, diff;
  logic        run_ind;

  // byte-lane merge for 16-bit registers
  function automatic dso_freq_t wmerge(input dso_freq_t o, input logic [31:0] d,
                                       input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // one request per ack; ack drops the cycle after it was given
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  // register writes; unmapped writes are acked and dropped
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sel_d[i] = sel_q[i];
    end
    setf_d   = setf_q;
    accth_d  = accth_q;
    decth_d  = decth_q;
    startf_d = startf_q;
    maxf_d   = maxf_q;
    imask_d  = imask_q;
    ack_d    = req;
    // unknown codes are stored and read back as written; they leave the contact open
    if (wr) begin
      unique case (adr)
        `DSO_SEL0_OFS:   if (wb_sel_i[0]) sel_d[0] = wb_dat_i[7:0];
        `DSO_SEL1_OFS:   if (wb_sel_i[0]) sel_d[1] = wb_dat_i[7:0];
        `DSO_SEL2_OFS:   if (wb_sel_i[0]) sel_d[2] = wb_dat_i[7:0];
        `DSO_SETF_OFS:   setf_d   = wmerge(setf_q, wb_dat_i, wb_sel_i);
        `DSO_ACCTH_OFS:  accth_d  = wmerge(accth_q, wb_dat_i, wb_sel_i);
        `DSO_DECTH_OFS:  decth_d  = wmerge(decth_q, wb_dat_i, wb_sel_i);
        `DSO_STARTF_OFS: startf_d = wmerge(startf_q, wb_dat_i, wb_sel_i);
        `DSO_MAXF_OFS:   maxf_d   = wmerge(maxf_q, wb_dat_i, wb_sel_i);
        `DSO_IMASK_OFS:  if (wb_sel_i[0]) imask_d = wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q[0] <= DSO_FN_RUN;
      sel_q[1] <= DSO_FN_RUN;
      // a fresh reset hands the alarm relay back to the fault function
      sel_q[2] <= DSO_FN_ALARM;
      setf_q   <= `DSO_FREQ_RST;
      accth_q  <= `DSO_FREQ_RST;
      decth_q  <= `DSO_FREQ_RST;
      startf_q <= `DSO_STARTF_RST;
      maxf_q   <= `DSO_MAXF_RST;
      imask_q  <= 3'h0;
      ack_q    <= 1'b0;
    end else begin
      sel_q    <= sel_d;
      setf_q   <= setf_d;
      accth_q  <= accth_d;
      decth_q  <= decth_d;
      startf_q <= startf_d;
      maxf_q   <= maxf_d;
      imask_q  <= imask_d;
      ack_q    <= ack_d;
    end
  end

  // hysteresis widths follow the programmed maximum frequency
  // integer division truncates, so a band is never wider than its percentage
  assign hon  = maxf_q / `DSO_HYST_ON_DIV;
  assign hoff = maxf_q / `DSO_HYST_OFF_DIV;
  // distance to the setpoint, unsigned so one compare serves both sides
  assign diff = (out_freq_i >= setf_q) ? out_freq_i - setf_q : setf_q - out_freq_i;

  // run indicator needs both run mode and frequency above the start point
  assign run_ind = run_i && (out_freq_i > startf_q);

  // arrival indicators: between on and off bands the last state holds
  always_comb begin
    fa1_d = fa1_q;
    if (diff <= hon) begin
      fa1_d = 1'b1;
    end else if (diff > hoff) begin
      fa1_d = 1'b0;
    end
    // accel wins over decel if the drive reports both at once
    fa2_d = fa2_q;
    if (accel_i && ({1'b0, out_freq_i} + {1'b0, hon} >= {1'b0, accth_q})) begin
      fa2_d = 1'b1;
    end else if (decel_i && ({1'b0, out_freq_i} + {1'b0, hoff} < {1'b0, decth_q})) begin
      fa2_d = 1'b0;
    end
  end

  // each relay picks its source straight from the live selection code,
  // so a new code shows on the contacts two cycles after the write
  for (genvar g = 0; g < 3; g++) begin : g_relay
    always_comb begin
      unique case (sel_q[g])
        DSO_FN_RUN:   relay_d[g] = run_ind;
        DSO_FN_FA1:   relay_d[g] = fa1_d;
        DSO_FN_FA2:   relay_d[g] = fa2_d;
        DSO_FN_ALARM: relay_d[g] = fault_i;
        default:      relay_d[g] = 1'b0;
      endcase
    end
  end
  // both changeover contacts share one source, so they never close together
  assign nc_d = !relay_d[2];

  // changes of any relay set sticky bits; a set beats a same-cycle clear
  // a lost clear only repeats an interrupt, a lost event would hide one
  always_comb begin
    istat_d = istat_q;
    if (wr && adr == `DSO_ISTAT_OFS && wb_sel_i[0]) begin
      istat_d = istat_q & ~wb_dat_i[2:0];
    end
    istat_d = istat_d | (relay_d ^ relay_q);
    irq_d   = |(istat_d & imask_d);
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (adr)
        `DSO_SEL0_OFS:   rdat_d[7:0]  = sel_q[0];
        `DSO_SEL1_OFS:   rdat_d[7:0]  = sel_q[1];
        `DSO_SEL2_OFS:   rdat_d[7:0]  = sel_q[2];
        `DSO_SETF_OFS:   rdat_d[15:0] = setf_q;
        `DSO_ACCTH_OFS:  rdat_d[15:0] = accth_q;
        `DSO_DECTH_OFS:  rdat_d[15:0] = decth_q;
        `DSO_STARTF_OFS: rdat_d[15:0] = startf_q;
        `DSO_MAXF_OFS:   rdat_d[15:0] = maxf_q;
        `DSO_STAT_OFS: begin
          rdat_d[`DSO_ST_RUN_BIT] = run_ind;
          rdat_d[`DSO_ST_FA1_BIT] = fa1_q;
          rdat_d[`DSO_ST_FA2_BIT] = fa2_q;
          rdat_d[`DSO_ST_RLY_LSB +: 3] = relay_q;
        end
        `DSO_ISTAT_OFS:  rdat_d[2:0] = istat_q;
        `DSO_IMASK_OFS:  rdat_d[2:0] = imask_q;
        default: ;
      endcase
    end
  end

  // contacts are closed (1) for an active function; NO contacts open and the alarm NC contact closed at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fa1_q   <= 1'b0;
      fa2_q   <= 1'b0;
      relay_q <= 3'h0;
      nc_q    <= 1'b1;
      istat_q <= 3'h0;
      irq_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      fa1_q   <= fa1_d;
      fa2_q   <= fa2_d;
      relay_q <= relay_d;
      nc_q    <= nc_d;
      istat_q <= istat_d;
      irq_q   <= irq_d;
      rdat_q  <= rdat_d;
    end
  end

  assign relay1_o   = relay_q[0];
  assign relay2_o   = relay_q[1];
  assign alarm_no_o = relay_q[2];
  assign alarm_nc_o = nc_q;
  assign irq_o      = irq_q;
  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = rdat_q;

  // checks on the relay and indicator behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // steps of a selection change: the write, then the new code in place
  sequence s_wr_sel0;
    wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && adr == `DSO_SEL0_OFS && wb_sel_i[0];
  endsequence

  sequence s_fa2_on_cause;
    accel_i && ({1'b0, out_freq_i} + {1'b0, hon} >= {1'b0, accth_q});
  endsequence

  sequence s_fa2_decel_band;
    !accel_i && decel_i && ({1'b0, out_freq_i} + {1'b0, hoff} >= {1'b0, decth_q});
  endsequence

  AST_RUN_STOPPED: assert property (
    (sel_q[0] == DSO_FN_RUN && !run_i) |=> !relay1_o)
    else $error("run relay closed while stopped");
  AST_RUN_ABOVE_START: assert property (
    (sel_q[1] == DSO_FN_RUN && run_i && out_freq_i > startf_q) |=> relay2_o)
    else $error("run relay open above start frequency");
  AST_ALARM_DEFAULT: assert property (
    $fell(rst_i) |-> sel_q[2] == DSO_FN_ALARM)
    else $error("alarm relay not on fault function after reset");
  AST_FORM_C: assert property (
    alarm_nc_o == !alarm_no_o)
    else $error("changeover contacts disagree");
  AST_FA1_OFF_LATE: assert property (
    (diff > hoff) |=> !fa1_q)
    else $error("setpoint arrival held outside off band");
  AST_FA2_ON: assert property (
    s_fa2_on_cause |=> fa2_q)
    else $error("over-threshold arrival not on during accel");
  AST_FA2_OFF: assert property (
    (!accel_i && decel_i && ({1'b0, out_freq_i} + {1'b0, hoff} < {1'b0, decth_q}))
      |=> !fa2_q)
    else $error("over-threshold arrival not off during decel");
  AST_FA2_HOLD: assert property (
    (!accel_i && !decel_i) |=> fa2_q == $past(fa2_q))
    else $error("over-threshold arrival moved while cruising");
  AST_SEL_IMMEDIATE: assert property (
    s_wr_sel0 ##1 (sel_q[0] == DSO_FN_ALARM) |=> relay1_o == $past(fault_i))
    else $error("relay did not follow new selection");

  // setpoint arrival: the on band sits inside the off band
  AST_FA1_ON_EARLY: assert property (
    (diff <= hon) |=> fa1_q)
    else $error("setpoint arrival not on inside on band");
  AST_FA1_HOLD: assert property (
    (diff > hon && diff <= hoff) |=> fa1_q == $past(fa1_q))
    else $error("setpoint arrival moved between bands");

  // over-threshold arrival keeps its state in decel until below the off point
  AST_FA2_DECEL_HOLD: assert property (
    s_fa2_decel_band |=> fa2_q == $past(fa2_q))
    else $error("over-threshold arrival dropped above decel off point");

  // each relay follows its own code whatever the others carry
  AST_RELAY2_OWN: assert property (
    (sel_q[1] == DSO_FN_FA1) |=> relay2_o == fa1_q)
    else $error("second relay did not follow its own selection");
  AST_ALARM_FOLLOWS_FAULT: assert property (
    (sel_q[2] == DSO_FN_ALARM) |=> alarm_no_o == $past(fault_i))
    else $error("alarm relay did not follow fault");

endmodule

/* verif/dso_relay_load.sv */
/*
  Relay load model: coils fed through the status output contacts.
  Assumes contacts are levels on clk_i, closed when high.
*/
`timescale 1ns/1ps

module dso_relay_load (
  input  wire logic       clk_i,
  input  wire logic       relay1_i,
  input  wire logic       relay2_i,
  input  wire logic       alarm_no_i,
  input  wire logic       alarm_nc_i,
  output logic      [2:0] coil_o
);
  // coil pulls in a clock late; both alarm contacts closed would be a short
  always_ff @(posedge clk_i) begin
    coil_o <= {alarm_no_i & ~alarm_nc_i, relay2_i, relay1_i};
  end
endmodule

/* verif/drive_status_output_logic_bench.sv */
/*
  Self-checking bench of the drive status output block.
  Assumes the block answers classic Wishbone and a relay load reads it.
*/
`timescale 1ns/1ps
`include "dso_map.svh"

module drive_status_output_logic_bench
  import dso_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack, r1, r2, ano, anc, irq;
  logic        run   = 1'b0;
  logic        flt   = 1'b0;
  logic        acc   = 1'b0;
  logic        dec   = 1'b0;
  dso_freq_t   frq   = 16'h0000;
  logic [2:0]  coil;
  logic [7:0]  seed  = 8'h12;
  int          mismatches  = 0;
  int          checks_done = 0;

  // 100 ns period
  always #50 clk_i = ~clk_i;

  dso_status_out u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .run_i(run), .fault_i(flt), .accel_i(acc), .decel_i(dec),
    .out_freq_i(frq), .relay1_o(r1), .relay2_o(r2), .alarm_no_o(ano),
    .alarm_nc_o(anc), .irq_o(irq));

  dso_relay_load u_load (.clk_i(clk_i), .relay1_i(r1), .relay2_i(r2),
    .alarm_no_i(ano), .alarm_nc_i(anc), .coil_o(coil));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // run indicator expectation against the reset start frequency
  function automatic logic exp_run(input dso_freq_t f);
    return f > `DSO_STARTF_RST;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high on a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    repeat (20) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    rdat = dat_o;
    cyc <= 1'b0;
  endtask

  // new drive state, then look once the registered relays settle
  task automatic drv(input logic r, input logic a, input logic d, input dso_freq_t f);
    @(posedge clk_i);
    run <= r;
    acc <= a;
    dec <= d;
    frq <= f;
    repeat (2) @(negedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(anc, 1'b1);
    chk(r1, 1'b0);
    wb(1'b0, `DSO_SEL2_OFS, 32'h0);
    chk(rdat, 32'h5);
    wb(1'b0, `DSO_STARTF_OFS, 32'h0);
    chk(rdat, 32'h32);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, `DSO_ISTAT_OFS, 32'h7);
    wb(1'b1, `DSO_IMASK_OFS, 32'h1);
    // run function at the start frequency boundary
    drv(1'b1, 1'b0, 1'b0, 16'h0032);
    chk(r1, 1'b0);
    drv(1'b1, 1'b0, 1'b0, 16'h0033);
    chk(r1, 1'b1);
    chk(r2, 1'b1);
    chk(irq, 1'b1);
    @(negedge clk_i);
    chk(coil[0], 1'b1);
    wb(1'b1, `DSO_ISTAT_OFS, 32'h1);
    @(negedge clk_i);
    chk(irq, 1'b0);
    wb(1'b0, `DSO_ISTAT_OFS, 32'h0);
    chk(rdat, 32'h2);
    drv(1'b0, 1'b0, 1'b0, 16'h0033);
    chk(r1, 1'b0);
    wb(1'b1, `DSO_IMASK_OFS, 32'h0);
    @(negedge clk_i);
    chk(irq, 1'b0);
    // at-setpoint on relay 2, hon 0x3c and hoff 0x78 of 0x1770
    wb(1'b1, `DSO_SEL1_OFS, 32'h1);
    wb(1'b1, `DSO_SETF_OFS, 32'h1000);
    drv(1'b1, 1'b0, 1'b0, 16'h0fc3);
    chk(r2, 1'b0);
    drv(1'b1, 1'b0, 1'b0, 16'h0fc4);
    chk(r2, 1'b1);
    drv(1'b1, 1'b0, 1'b0, 16'h1078);
    chk(r2, 1'b1);
    drv(1'b1, 1'b0, 1'b0, 16'h1079);
    chk(r2, 1'b0);
    drv(1'b1, 1'b0, 1'b0, 16'h103d);
    chk(r2, 1'b0);
    // over-threshold on relay 1
    wb(1'b1, `DSO_SEL0_OFS, 32'h2);
    wb(1'b1, `DSO_ACCTH_OFS, 32'h0800);
    wb(1'b1, `DSO_DECTH_OFS, 32'h0400);
    drv(1'b1, 1'b1, 1'b0, 16'h07c3);
    chk(r1, 1'b0);
    drv(1'b1, 1'b1, 1'b0, 16'h07c4);
    chk(r1, 1'b1);
    drv(1'b1, 1'b0, 1'b1, 16'h0388);
    chk(r1, 1'b1);
    drv(1'b1, 1'b0, 1'b0, 16'h0100);
    chk(r1, 1'b1);
    drv(1'b1, 1'b0, 1'b1, 16'h0387);
    chk(r1, 1'b0);
    // alarm relay: fault by default, then reassigned to run
    @(posedge clk_i);
    flt <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(ano, 1'b1);
    chk(anc, 1'b0);
    wb(1'b1, `DSO_SEL2_OFS, 32'h0);
    drv(1'b0, 1'b0, 1'b0, 16'h0000);
    chk(ano, 1'b0);
    // relay 1 takes the fault function while relay 2 keeps its own
    wb(1'b1, `DSO_SEL0_OFS, 32'h5);
    @(negedge clk_i);
    chk(r1, 1'b1);
    chk(r2, 1'b0);
    // random frequencies on the run function
    wb(1'b1, `DSO_SEL0_OFS, 32'h0);
    repeat (40) begin
      seed = lfsr(seed);
      drv(1'b1, 1'b0, 1'b0, {7'h0, seed, 1'b0});
      chk(r1, exp_run({7'h0, seed, 1'b0}));
    end
    report_and_stop();
  end
endmodule
